// *** tpr_top.v ***
// Trip reset policy, restart timing, current-limit trip and drive settings with Wishbone access
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`include "tpr_defines.vh"
//
// Function
// - Policy 0: clear only on manual request
// - Policies 1,3,10 auto restart, capped attempts
// - Policy 11: clear at power-up after fault
// - Auto reset starts after programmed wait
// - Attempts spaced by the same wait
// - Trip after continuous current-limit delay
// - Delay 61 disables current-limit trip
// - Switching rate follows programmed value
// - Output frequency clamped to rate/10
// - Rate lowered automatically under heavy load
// - Overmodulation code 1 allows 5% boost
// - Overmodulation code 0 forbids boost
// - Brake codes 1 resistor, 4 AC
// - New brake mode applies after power cycle
// - Feedback display scales linearly low..high
// - Process unit codes 0 through 40
module tpr_top #(
  parameter TICK_CYCLES = `TPR_TICK_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire keypad_clear_i,
  input wire din_reset_i,
  input wire fault_i,
  input wire mains_ok_i,
  input wire at_current_limit_i,
  input wire [7:0] load_i,
  input wire [15:0] freq_cmd_i,
  input wire [11:0] fb_raw_i,
  output reg [15:0] freq_out_o,
  output reg [13:0] inverter_switching_rate_o,
  output reg trip_o,
  output reg overmod_en_o,
  output reg [2:0] brake_mode_o,
  output reg [5:0] process_unit_select_o,
  output reg speed_loop_o,
  output reg process_loop_o,
  output reg [31:0] fb_display_o,
  output wire irq_o
);
  localparam ST_RUN = 4'b0001;
  localparam ST_HOLD = 4'b0010;
  localparam ST_WAIT = 4'b0100;
  localparam ST_LOCK = 4'b1000;
  localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
  localparam [26:0] TICK_LAST = TICK_LAST_W[26:0];

  function [3:0] tpr_attempts;
    input [3:0] policy;
    begin
      case (policy)
        `TPR_POLICY_AUTO1: tpr_attempts = 4'h1;
        `TPR_POLICY_AUTO3: tpr_attempts = 4'h3;
        `TPR_POLICY_AUTO10: tpr_attempts = 4'hA;
        default: tpr_attempts = 4'h0;
      endcase
    end
  endfunction

  function [13:0] tpr_rate_clamp;
    input [13:0] r;
    begin
      if (r < `TPR_RATE_MIN) begin
        tpr_rate_clamp = `TPR_RATE_MIN;
      end else if (r > `TPR_RATE_MAX) begin
        tpr_rate_clamp = `TPR_RATE_MAX;
      end else begin
        tpr_rate_clamp = r;
      end
    end
  endfunction

  // Registers
  reg [3:0] reset_policy;
  reg [3:0] restart_wait_time;
  reg [5:0] trip_delay;
  reg [13:0] rate_prog;
  reg brake_pending_valid;
  reg [2:0] brake_pending;
  reg [1:0] config_sel;
  reg signed [31:0] feedback_scale_low;
  reg signed [31:0] feedback_scale_high;
  reg [`TPR_IRQ_W-1:0] irq_stat;
  reg [`TPR_IRQ_W-1:0] irq_mask;

  // Pin synchronisers
  reg [1:0] key_sync;
  reg [1:0] din_sync;
  reg [1:0] fault_sync;
  reg [1:0] mains_sync;
  reg key_prev;
  reg din_prev;
  reg fault_prev;
  reg mains_prev;

  reg [3:0] state;
  reg [3:0] attempts_left;
  reg [26:0] wait_pre;
  reg [3:0] wait_sec;
  reg [26:0] limit_pre;
  reg [5:0] limit_sec;
  reg fault_at_loss;

  wire wr = cyc_i & stb_i & we_i & ~ack_o;
  wire wr_all = wr & (&sel_i);
  wire key_rise = key_sync[1] & ~key_prev;
  wire din_rise = din_sync[1] & ~din_prev;
  wire fault_rise = fault_sync[1] & ~fault_prev;
  wire mains_fall = ~mains_sync[1] & mains_prev;
  wire mains_rise = mains_sync[1] & ~mains_prev;
  wire serial_clear = wr & sel_i[0] & (adr_i == `TPR_ADR_CMD) & dat_i[`TPR_F_CMD_CLEAR];
  wire manual_req = key_rise | din_rise | serial_clear;
  wire is_auto = (tpr_attempts(reset_policy) != 4'h0);
  wire limit_trip = (state == ST_RUN) & at_current_limit_i & (trip_delay != `TPR_TRIPDLY_OFF) &
                    (limit_sec >= trip_delay);
  wire trip_evt = (state == ST_RUN) & (fault_rise | limit_trip);
  wire wait_done = (wait_sec >= restart_wait_time);
  wire powerup_clear = mains_rise & (reset_policy == `TPR_POLICY_POWERUP) & fault_at_loss;
  reg [13:0] next_rate;
  reg [15:0] next_freq;
  reg [13:0] rate_half;
  wire [15:0] freq_cap = {2'h0, inverter_switching_rate_o / `TPR_RATE_DIV};
  wire [31:0] fb_disp;
  reg [`TPR_IRQ_W-1:0] irq_evt;

  always @(posedge clk_i) begin
    if (rst_i) begin
      key_sync <= 2'h0;
      din_sync <= 2'h0;
      fault_sync <= 2'h0;
      mains_sync <= 2'h0;
      key_prev <= 1'h0;
      din_prev <= 1'h0;
      fault_prev <= 1'h0;
      mains_prev <= 1'h0;
    end else begin
      key_sync <= {key_sync[0], keypad_clear_i};
      din_sync <= {din_sync[0], din_reset_i};
      fault_sync <= {fault_sync[0], fault_i};
      mains_sync <= {mains_sync[0], mains_ok_i};
      key_prev <= key_sync[1];
      din_prev <= din_sync[1];
      fault_prev <= fault_sync[1];
      mains_prev <= mains_sync[1];
    end
  end

  // Trip and restart sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_RUN;
      attempts_left <= 4'h0;
      wait_pre <= 27'h0;
      wait_sec <= 4'h0;
    end else begin
      case (state)
        ST_RUN: begin
          if (trip_evt) begin
            wait_pre <= 27'h0;
            wait_sec <= 4'h0;
            if (is_auto && attempts_left != 4'h0) begin
              state <= ST_WAIT;
            end else if (is_auto) begin
              state <= ST_LOCK;
            end else begin
              state <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (manual_req || powerup_clear) begin
            state <= ST_RUN;
            attempts_left <= tpr_attempts(reset_policy);
          end
        end
        ST_WAIT: begin
          if (manual_req) begin
            state <= ST_RUN;
            attempts_left <= tpr_attempts(reset_policy);
          end else if (wait_done) begin
            state <= ST_RUN;
            attempts_left <= attempts_left - 4'h1;
          end else if (wait_pre == TICK_LAST) begin
            wait_pre <= 27'h0;
            wait_sec <= wait_sec + 4'h1;
          end else begin
            wait_pre <= wait_pre + 27'h1;
          end
        end
        ST_LOCK: begin
          if (manual_req) begin
            state <= ST_RUN;
            attempts_left <= tpr_attempts(reset_policy);
          end
        end
        default: state <= ST_RUN;
      endcase
      // A fresh policy reloads the attempt budget
      if (wr_all && adr_i == `TPR_ADR_RESET_CFG) begin
        attempts_left <= tpr_attempts(dat_i[`TPR_F_POLICY]);
      end
    end
  end

  // Time spent continuously at the current limit
  always @(posedge clk_i) begin
    if (rst_i) begin
      limit_pre <= 27'h0;
      limit_sec <= 6'h0;
    end else if (!at_current_limit_i || state != ST_RUN) begin
      limit_pre <= 27'h0;
      limit_sec <= 6'h0;
    end else if (limit_pre == TICK_LAST) begin
      limit_pre <= 27'h0;
      if (limit_sec != 6'h3F) begin
        limit_sec <= limit_sec + 6'h1;
      end
    end else begin
      limit_pre <= limit_pre + 27'h1;
    end
  end

  // Mains loss memory and power-cycle gated brake change
  always @(posedge clk_i) begin
    if (rst_i) begin
      fault_at_loss <= 1'h0;
      brake_mode_o <= `TPR_BRAKE_OFF;
    end else begin
      if (mains_fall) begin
        fault_at_loss <= (state != ST_RUN) | fault_sync[1];
      end else if (mains_rise) begin
        fault_at_loss <= 1'h0;
      end
      if (mains_rise && brake_pending_valid) begin
        brake_mode_o <= brake_pending;
      end
    end
  end

  // Register writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      reset_policy <= `TPR_POLICY_MANUAL;
      restart_wait_time <= `TPR_WAIT_RST;
      trip_delay <= `TPR_TRIPDLY_RST;
      rate_prog <= `TPR_RATE_RST;
      overmod_en_o <= `TPR_OVERMOD_RST;
      brake_pending <= `TPR_BRAKE_OFF;
      brake_pending_valid <= 1'h0;
      process_unit_select_o <= 6'h0;
      config_sel <= 2'h0;
      feedback_scale_low <= `TPR_FB_LOW_RST;
      feedback_scale_high <= `TPR_FB_HIGH_RST;
      irq_mask <= {`TPR_IRQ_W{1'b0}};
    end else if (wr_all) begin
      case (adr_i)
        `TPR_ADR_RESET_CFG: begin
          case (dat_i[`TPR_F_POLICY])
            `TPR_POLICY_MANUAL, `TPR_POLICY_AUTO1, `TPR_POLICY_AUTO3, `TPR_POLICY_AUTO10,
            `TPR_POLICY_POWERUP: reset_policy <= dat_i[`TPR_F_POLICY];
            default: reset_policy <= reset_policy;
          endcase
          if (dat_i[`TPR_F_WAIT] <= `TPR_WAIT_MAX) begin
            restart_wait_time <= dat_i[`TPR_F_WAIT];
          end
        end
        `TPR_ADR_TRIP_CFG: begin
          if (dat_i[`TPR_F_TRIPDLY] <= `TPR_TRIPDLY_OFF) begin
            trip_delay <= dat_i[`TPR_F_TRIPDLY];
          end
        end
        `TPR_ADR_SWITCH: rate_prog <= tpr_rate_clamp(dat_i[`TPR_F_RATE]);
        `TPR_ADR_DRIVE_CFG: begin
          overmod_en_o <= dat_i[`TPR_F_OVERMOD];
          if (dat_i[`TPR_F_BRAKE] == `TPR_BRAKE_OFF || dat_i[`TPR_F_BRAKE] == `TPR_BRAKE_RESISTOR ||
              dat_i[`TPR_F_BRAKE] == `TPR_BRAKE_AC) begin
            brake_pending <= dat_i[`TPR_F_BRAKE];
            brake_pending_valid <= 1'h1;
          end
          if (dat_i[`TPR_F_UNIT] <= `TPR_UNIT_MAX) begin
            process_unit_select_o <= dat_i[`TPR_F_UNIT];
          end
          config_sel <= dat_i[`TPR_F_CFG];
        end
        `TPR_ADR_FB_LOW: begin
          if ($signed(dat_i) >= $signed(`TPR_FB_LOW_MIN) && $signed(dat_i) <= feedback_scale_high) begin
            feedback_scale_low <= dat_i;
          end
        end
        `TPR_ADR_FB_HIGH: begin
          if ($signed(dat_i) >= feedback_scale_low) begin
            feedback_scale_high <= dat_i;
          end
        end
        `TPR_ADR_IRQ_MASK: irq_mask <= dat_i[`TPR_IRQ_W-1:0];
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // Load derating of the switching rate and frequency clamp
  always @* begin
    rate_half = rate_prog >> 1;
    next_rate = rate_prog;
    if (load_i >= `TPR_DERATE_LOAD) begin
      next_rate = tpr_rate_clamp(rate_half);
    end
    next_freq = freq_cmd_i;
    if (freq_cmd_i > freq_cap) begin
      next_freq = freq_cap;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      inverter_switching_rate_o <= `TPR_RATE_RST;
      freq_out_o <= 16'h0000;
      trip_o <= 1'h0;
      speed_loop_o <= 1'h0;
      process_loop_o <= 1'h0;
      fb_display_o <= 32'h00000000;
    end else begin
      inverter_switching_rate_o <= next_rate;
      // Tripped drive holds its output disconnected
      freq_out_o <= (state == ST_RUN) ? next_freq : 16'h0000;
      trip_o <= (state != ST_RUN);
      speed_loop_o <= (config_sel == `TPR_CFG_SPEED);
      process_loop_o <= (config_sel == `TPR_CFG_PROCESS);
      fb_display_o <= fb_disp;
    end
  end

  tpr_fbscale u_fbscale (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(fb_raw_i),
    .low_i(feedback_scale_low),
    .high_i(feedback_scale_high),
    .disp_o(fb_disp)
  );

  // Sticky events; a new event wins over a write-one clear
  always @* begin
    irq_evt = {`TPR_IRQ_W{1'b0}};
    irq_evt[`TPR_IRQ_TRIP] = trip_evt;
    irq_evt[`TPR_IRQ_RESTART] = (state == ST_WAIT) & ~manual_req & wait_done;
    irq_evt[`TPR_IRQ_LOCKOUT] = trip_evt & is_auto & (attempts_left == 4'h0);
    irq_evt[`TPR_IRQ_LIMIT] = limit_trip;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= {`TPR_IRQ_W{1'b0}};
    end else if (wr && sel_i[0] && adr_i == `TPR_ADR_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~dat_i[`TPR_IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat <= irq_stat | irq_evt;
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // Single-wait-state slave; unmapped reads return zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'h0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      case (adr_i)
        `TPR_ADR_RESET_CFG: dat_o <= {24'h0, restart_wait_time, reset_policy};
        `TPR_ADR_TRIP_CFG: dat_o <= {26'h0, trip_delay};
        `TPR_ADR_SWITCH: dat_o <= {18'h0, rate_prog};
        `TPR_ADR_DRIVE_CFG: dat_o <= {20'h0, config_sel, process_unit_select_o, brake_pending, overmod_en_o};
        `TPR_ADR_FB_LOW: dat_o <= feedback_scale_low;
        `TPR_ADR_FB_HIGH: dat_o <= feedback_scale_high;
        `TPR_ADR_STATUS: dat_o <= {16'h0, 1'h0, brake_mode_o, fault_at_loss, 3'h0, attempts_left, state};
        `TPR_ADR_IRQ_STAT: dat_o <= {28'h0, irq_stat};
        `TPR_ADR_IRQ_MASK: dat_o <= {28'h0, irq_mask};
        `TPR_ADR_ACTIVE: dat_o <= {freq_out_o, 2'h0, inverter_switching_rate_o};
        `TPR_ADR_FB_DISP: dat_o <= fb_display_o;
        default: dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule

// *** tpr_defines.vh ***
// Register map, field layout, reset values and timing counts of the trip/restart protection block
`ifndef TPR_DEFINES_VH
`define TPR_DEFINES_VH

`define TPR_CLK_PERIOD_NS 8
`define TPR_SECOND_NS 1000000000
`define TPR_TICK_CYCLES (`TPR_SECOND_NS / `TPR_CLK_PERIOD_NS)

`define TPR_ADR_RESET_CFG 8'h00
`define TPR_ADR_TRIP_CFG 8'h04
`define TPR_ADR_SWITCH 8'h08
`define TPR_ADR_DRIVE_CFG 8'h0C
`define TPR_ADR_FB_LOW 8'h10
`define TPR_ADR_FB_HIGH 8'h14
`define TPR_ADR_STATUS 8'h18
`define TPR_ADR_IRQ_STAT 8'h1C
`define TPR_ADR_IRQ_MASK 8'h20
`define TPR_ADR_CMD 8'h24
`define TPR_ADR_ACTIVE 8'h28
`define TPR_ADR_FB_DISP 8'h2C

`define TPR_POLICY_MANUAL 4'h0
`define TPR_POLICY_AUTO1 4'h1
`define TPR_POLICY_AUTO3 4'h3
`define TPR_POLICY_AUTO10 4'hA
`define TPR_POLICY_POWERUP 4'hB

`define TPR_WAIT_RST 4'h5
`define TPR_WAIT_MAX 4'hA
`define TPR_TRIPDLY_RST 6'h3D
`define TPR_TRIPDLY_OFF 6'h3D
`define TPR_RATE_RST 14'h1194
`define TPR_RATE_MIN 14'h0BB8
`define TPR_RATE_MAX 14'h36B0
`define TPR_RATE_DIV 14'h000A
`define TPR_OVERMOD_RST 1'h1
`define TPR_BRAKE_OFF 3'h0
`define TPR_BRAKE_RESISTOR 3'h1
`define TPR_BRAKE_AC 3'h4
`define TPR_UNIT_MAX 6'h28
`define TPR_CFG_SPEED 2'h1
`define TPR_CFG_PROCESS 2'h3
`define TPR_FB_LOW_RST 32'h00000000
`define TPR_FB_HIGH_RST 32'h0016E360
`define TPR_FB_LOW_MIN 32'hFA0A1F00
`define TPR_FB_FULL 12'hFFF
`define TPR_DERATE_LOAD 8'hC0

`define TPR_F_POLICY 3:0
`define TPR_F_WAIT 7:4
`define TPR_F_TRIPDLY 5:0
`define TPR_F_RATE 13:0
`define TPR_F_OVERMOD 0
`define TPR_F_BRAKE 3:1
`define TPR_F_UNIT 9:4
`define TPR_F_CFG 11:10
`define TPR_F_CMD_CLEAR 0

`define TPR_IRQ_TRIP 0
`define TPR_IRQ_RESTART 1
`define TPR_IRQ_LOCKOUT 2
`define TPR_IRQ_LIMIT 3
`define TPR_IRQ_W 4

`endif

// *** tpr_fbscale.v ***
// Linear feedback display scaling between two programmable points
`timescale 1ns/100ps
`include "tpr_defines.vh"
module tpr_fbscale (
  input wire clk_i,
  input wire rst_i,
  input wire [11:0] raw_i,
  input wire signed [31:0] low_i,
  input wire signed [31:0] high_i,
  output reg signed [31:0] disp_o
);
  wire signed [32:0] span;
  wire signed [45:0] prod;
  wire signed [45:0] frac;
  wire signed [45:0] sum;

  assign span = {high_i[31], high_i} - {low_i[31], low_i};
  assign prod = span * $signed({1'b0, raw_i});
  // Full scale input lands exactly on the high point
  assign frac = prod / $signed({34'h0, `TPR_FB_FULL});
  assign sum = frac + {{14{low_i[31]}}, low_i};

  always @(posedge clk_i) begin
    if (rst_i) begin
      disp_o <= 32'h00000000;
    end else begin
      disp_o <= sum[31:0];
    end
  end
endmodule

// *** tpr_top_monitor.sv ***
// Concurrent checks on the trip/restart protection block ports
`timescale 1ns/100ps
module tpr_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire mains_ok_i,
  input wire [15:0] freq_out_o,
  input wire [13:0] inverter_switching_rate_o,
  input wire trip_o,
  input wire [2:0] brake_mode_o,
  input wire [5:0] process_unit_select_o,
  input wire speed_loop_o,
  input wire process_loop_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_rate_in_range: assert property (inverter_switching_rate_o >= 14'h0BB8 && inverter_switching_rate_o <= 14'h36B0)
    else $error("switching rate out of range");
  // Previous rate allowed too, since both outputs are registered
  a_freq_tenth_rate: assert property (({16'h0000, freq_out_o} * 32'h0000000A <= inverter_switching_rate_o) ||
    ({16'h0000, freq_out_o} * 32'h0000000A <= $past(inverter_switching_rate_o)))
    else $error("output frequency above rate over ten");
  a_trip_no_freq: assert property (trip_o && $past(trip_o) |-> freq_out_o == 16'h0000)
    else $error("output not disconnected while tripped");
  a_loop_exclusive: assert property (!(speed_loop_o && process_loop_o))
    else $error("both regulators selected");
  a_unit_in_range: assert property (process_unit_select_o <= 6'h28)
    else $error("process unit above 40");
  a_brake_code_legal: assert property (brake_mode_o == 3'h0 || brake_mode_o == 3'h1 || brake_mode_o == 3'h4)
    else $error("illegal brake mode");
  // Mains steady high means no restore edge is in flight
  a_brake_power_cycle: assert property (mains_ok_i [*8] |-> $stable(brake_mode_o))
    else $error("brake mode changed without power cycle");

  c_trip: cover property ($rose(trip_o));
  c_restart: cover property ($fell(trip_o));
  c_brake: cover property ($changed(brake_mode_o));
  c_process: cover property (process_loop_o);
endmodule

bind tpr_top tpr_monitor u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .mains_ok_i(mains_ok_i),
  .freq_out_o(freq_out_o), .inverter_switching_rate_o(inverter_switching_rate_o), .trip_o(trip_o),
  .brake_mode_o(brake_mode_o), .process_unit_select_o(process_unit_select_o), .speed_loop_o(speed_loop_o),
  .process_loop_o(process_loop_o)
);

// *** tpr_operator_model.sv ***
// Operator side model: keypad clear key and digital reset input
`timescale 1ns/100ps
module tpr_operator_model (
  input wire clk_i,
  output logic keypad_clear_o,
  output logic din_reset_o
);
  initial begin
    keypad_clear_o = 1'b0;
    din_reset_o = 1'b0;
  end

  // Release drives both lines low, whichever was pressed
  task press(input logic use_din, input int len);
    begin
      @(posedge clk_i);
      if (use_din) din_reset_o <= 1'b1;
      else keypad_clear_o <= 1'b1;
      repeat (len) @(posedge clk_i);
      keypad_clear_o <= 1'b0;
      din_reset_o <= 1'b0;
    end
  endtask
endmodule

// *** tpr_top_tb.sv ***
// Self-checking testbench for the trip/restart protection block
`timescale 1ns/100ps
`include "tpr_defines.vh"
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin n_fail++; $display("mismatch at %0t: %0h vs %0h", $time, g, x); end end
module tpr_top_tb;
  localparam int T = 20;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic fault = 1'b0, mains = 1'b0, at_lim = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00, load = 8'h00;
  logic [11:0] raw = 12'h000;
  logic [15:0] fcmd = 16'h0000, seed = 16'hDEF5;
  logic [31:0] wdat = 32'h0, rd;
  logic [7:0] radr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h3C};
  logic [31:0] rval [8] = '{32'h50, 32'h3D, 32'h1194, 32'h1, 32'h0, 32'h16E360, 32'h0, 32'h0};
  wire ack, key, din, trip, ovm, spd, prc, irq;
  wire [31:0] dat, fbd;
  wire [15:0] fout;
  wire [13:0] rate;
  wire [5:0] unit;
  wire [2:0] brk;
  integer n_fail = 0, n_checks = 0, d, er, att, w;
  longint ef;
  int pol [3] = '{1, 3, 10};

  always #4 clk_i = ~clk_i;

  tpr_top #(.TICK_CYCLES(T)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(dat), .ack_o(ack), .keypad_clear_i(key), .din_reset_i(din), .fault_i(fault),
    .mains_ok_i(mains), .at_current_limit_i(at_lim), .load_i(load), .freq_cmd_i(fcmd), .fb_raw_i(raw),
    .freq_out_o(fout), .inverter_switching_rate_o(rate), .trip_o(trip), .overmod_en_o(ovm),
    .brake_mode_o(brk), .process_unit_select_o(unit), .speed_loop_o(spd), .process_loop_o(prc),
    .fb_display_o(fbd), .irq_o(irq)
  );
  tpr_operator_model op (.clk_i(clk_i), .keypad_clear_o(key), .din_reset_o(din));

  function automatic [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Master waits for ack with no assumed latency
  task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] dd);
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w_en;
      adr <= a;
      wdat <= dd;
      sel <= 4'hF;
      @(posedge clk_i);
      // Only the watchdog ends a hung bus wait
      while (ack !== 1'b1) begin
        @(posedge clk_i);
      end
      rd = dat;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask

  task automatic wait_trip(input logic v, output integer n);
    begin
      n = 0;
      while (trip !== v && n < 400) begin
        @(posedge clk_i);
        n++;
      end
    end
  endtask

  task automatic pulse_fault();
    begin
      @(posedge clk_i);
      fault <= 1'b1;
      repeat (4) @(posedge clk_i);
      fault <= 1'b0;
    end
  endtask

  task automatic mains_cycle();
    begin
      @(posedge clk_i);
      mains <= 1'b0;
      repeat (8) @(posedge clk_i);
      mains <= 1'b1;
      repeat (8) @(posedge clk_i);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished, %0d checks", s, n_checks);
  endtask

  task automatic conclude();
    begin
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask

  initial begin
    #400000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    mains <= 1'b1;
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, radr[i], 32'h0);
      `CHK(rd, rval[i])
    end
    `CHK(ovm, 1'b1)
    done("reset");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      er = (i == 0) ? 3000 : (i == 1) ? 14000 : 3000 + seed % 11001;
      seed = lfsr(seed);
      fcmd <= seed;
      load <= i[0] ? (8'hC0 | seed[7:0]) : (seed[7:0] & 8'hBF);
      wb(1'b1, `TPR_ADR_SWITCH, er);
      repeat (4) @(posedge clk_i);
      if (load >= `TPR_DERATE_LOAD) er = (er / 2 < 3000) ? 3000 : er / 2;
      `CHK(rate, er)
      `CHK(fout, (fcmd < er / 10) ? fcmd : er / 10)
    end
    load <= 8'h00;
    wb(1'b1, `TPR_ADR_SWITCH, 32'h7D0);
    repeat (4) @(posedge clk_i);
    `CHK(rate, 14'h0BB8)
    done("rate");
    wb(1'b1, `TPR_ADR_DRIVE_CFG, 32'hE82);
    repeat (2) @(posedge clk_i);
    `CHK({ovm, unit, prc, spd, brk}, {1'b0, 6'h28, 1'b1, 1'b0, 3'h0})
    mains_cycle();
    `CHK(brk, 3'h1)
    wb(1'b1, `TPR_ADR_DRIVE_CFG, 32'h409);
    repeat (2) @(posedge clk_i);
    `CHK({ovm, spd, prc, brk}, {1'b1, 1'b1, 1'b0, 3'h1})
    done("drive");
    for (int s = 0; s < 3; s++) begin
      pulse_fault();
      wait_trip(1'b1, d);
      repeat (5 * T + 40) @(posedge clk_i);
      `CHK(trip, 1'b1)
      if (s < 2) op.press(s[0], 4);
      else wb(1'b1, `TPR_ADR_CMD, 32'h1);
      wait_trip(1'b0, d);
      `CHK(trip, 1'b0)
    end
    done("manual");
    // Attempts left is modelled by att, counting down per trip
    for (int p = 0; p < 3; p++) begin
      w = (pol[p] == 3) ? 1 : 2;
      wb(1'b1, `TPR_ADR_RESET_CFG, (w << 4) | pol[p]);
      for (att = pol[p]; att >= 0; att--) begin
        pulse_fault();
        wait_trip(1'b1, d);
        if (att > 0) begin
          wait_trip(1'b0, d);
          `CHK(d >= w * T && d <= w * T + 2, 1'b1)
        end else begin
          repeat (3 * w * T) @(posedge clk_i);
          `CHK(trip, 1'b1)
        end
      end
      op.press(1'b1, 4);
      wait_trip(1'b0, d);
      `CHK(trip, 1'b0)
    end
    wb(1'b1, `TPR_ADR_IRQ_MASK, 32'h4);
    `CHK(irq, 1'b1)
    wb(1'b1, `TPR_ADR_IRQ_MASK, 32'h0);
    `CHK(irq, 1'b0)
    wb(1'b1, `TPR_ADR_IRQ_MASK, 32'h4);
    wb(1'b1, `TPR_ADR_IRQ_STAT, 32'h4);
    @(posedge clk_i);
    `CHK(irq, 1'b0)
    wb(1'b0, `TPR_ADR_IRQ_STAT, 32'h0);
    `CHK(rd, 32'h3)
    done("auto");
    wb(1'b1, `TPR_ADR_RESET_CFG, 32'h50);
    wb(1'b1, `TPR_ADR_TRIP_CFG, 32'h2);
    at_lim <= 1'b1;
    repeat (2 * T - 6) @(posedge clk_i);
    at_lim <= 1'b0;
    repeat (6) @(posedge clk_i);
    `CHK(trip, 1'b0)
    at_lim <= 1'b1;
    wait_trip(1'b1, d);
    `CHK(d >= 2 * T - 1 && d <= 2 * T + 3, 1'b1)
    at_lim <= 1'b0;
    wb(1'b1, `TPR_ADR_CMD, 32'h1);
    wait_trip(1'b0, d);
    wb(1'b1, `TPR_ADR_TRIP_CFG, 32'h3D);
    at_lim <= 1'b1;
    repeat (3 * T) @(posedge clk_i);
    `CHK(trip, 1'b0)
    at_lim <= 1'b0;
    done("limit");
    wb(1'b1, `TPR_ADR_DRIVE_CFG, 32'h409);
    wb(1'b1, `TPR_ADR_RESET_CFG, 32'h5B);
    pulse_fault();
    wait_trip(1'b1, d);
    mains_cycle();
    `CHK(trip, 1'b0)
    `CHK(brk, 3'h4)
    done("powerup");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      raw <= (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : seed[11:0];
      repeat (4) @(posedge clk_i);
      ef = 64'sh16E360 * raw / 4095;
      `CHK(fbd, ef[31:0])
    end
    done("feedback");
    conclude();
  end
endmodule
